/* hdl/mcsel_host.sv */
// Summary of operation
// RULE1 - each socket alone takes 2K RAM or any ROM; 4K/8K RAM per group
// RULE2 - low group strap sets sockets 0-3, high strap sockets 4-7 to big RAM
// RULE3 - a disabled socket never gets its chip select
// RULE4 - data buffer ignores requests to a disabled socket's range
// RULE5 - any socket set may be disabled; 2K blocks on 2K boundaries in 64K
// RULE6 - extension line gates the whole card or picks one of two halves
// RULE7 - card enabled on low extension line; polarity strap inverts it
// RULE8 - ignore strap ties extension line low, card always enabled
// RULE9 - two-bank mode: card enable fixed, extension line feeds decoder option
// RULE10 - decoder option input low with strap fitted, high without
// RULE11 - dual-bank options share one field: sockets 0-3 or sockets 4-7
// RULE12 - low extension picks lower bank, high picks upper, both 8000-FFFF
// RULE13 - card enabled on high segment line; polarity strap inverts it
// RULE14 - segment input pulled up, so unconnected means enabled by default
// RULE15 - with inverted polarity the controller actively drives segment low
// RULE16 - the controller always drives the extension line, never floats it
// RULE17 - cards sharing a field get opposite polarity; one responds at a time
// RULE18 - one dedicated segment output bit per card, eight from one port
// RULE19 - select needs request, both enables, socket enabled and decoded
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module mcsel_host import mcsel_pkg::*; #(
	parameter int NCARDS = 8,
	parameter int AW = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [15:0] bus_addr,
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe_n,
	output logic memrq_n,
	output logic rd_n,
	output logic wr_n,
	output logic memex_out,
	output logic [NCARDS-1:0] segment_sel
);
	// ****************************************
	// register bus slave
	// ****************************************
	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
		hit = (a[7:0] == ofs);
	endfunction : hit

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[8*b +: 8] = nw[8*b +: 8];
			end
		end
	endfunction : merge

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_held_q, w_held_q;
	logic [AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [31:0] ctrl_q, seg_en_q, seg_pol_q, addr_q, wbyte_q;
	logic aw_take, w_take, do_write, ar_take, aw_held_d, w_held_d, rvalid_d;
	logic wr_hit_any, start_rd, start_wr;
	mcsel_state_t state_q;
	logic [7:0] rd_byte_q;

	assign aw_take = awvalid && awready_q;
	assign w_take = wvalid && wready_q;
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign aw_held_d = do_write ? 1'b0 : (aw_take ? 1'b1 : aw_held_q);
	assign w_held_d = do_write ? 1'b0 : (w_take ? 1'b1 : w_held_q);
	assign ar_take = arvalid && arready_q;
	assign rvalid_d = ar_take ? 1'b1 : ((rvalid_q && rready) ? 1'b0 : rvalid_q);
	assign wr_hit_any = hit(awaddr_q, OFS_CTRL) || hit(awaddr_q, OFS_SEG_EN)
		|| hit(awaddr_q, OFS_SEG_POL) || hit(awaddr_q, OFS_ADDR)
		|| hit(awaddr_q, OFS_WDATA) || hit(awaddr_q, OFS_CMD);
	assign start_rd = do_write && hit(awaddr_q, OFS_CMD) && wstrb_q[0]
		&& wdata_q[CMD_RD_BIT] && (state_q == MCSEL_IDLE);
	assign start_wr = do_write && hit(awaddr_q, OFS_CMD) && wstrb_q[0]
		&& wdata_q[CMD_WR_BIT] && !wdata_q[CMD_RD_BIT] && (state_q == MCSEL_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= REG_RESET;
			wstrb_q <= '0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= !aw_held_d;
			wready_q <= !w_held_d;
			if (aw_take) begin
				awaddr_q <= awaddr;
			end
			if (w_take) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit_any ? RESP_OKAY : RESP_DECERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// control registers; extension level comes up low and is always driven
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= REG_RESET;
			seg_en_q <= REG_RESET;
			seg_pol_q <= REG_RESET;
			addr_q <= REG_RESET;
			wbyte_q <= REG_RESET;
		end else if (do_write) begin
			if (hit(awaddr_q, OFS_CTRL)) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q); // RULE16
			if (hit(awaddr_q, OFS_SEG_EN)) seg_en_q <= merge(seg_en_q, wdata_q, wstrb_q);
			if (hit(awaddr_q, OFS_SEG_POL)) seg_pol_q <= merge(seg_pol_q, wdata_q, wstrb_q);
			if (hit(awaddr_q, OFS_ADDR)) addr_q <= merge(addr_q, wdata_q, wstrb_q);
			if (hit(awaddr_q, OFS_WDATA)) wbyte_q <= merge(wbyte_q, wdata_q, wstrb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b0;
			rdata_q <= REG_RESET;
			rresp_q <= RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			arready_q <= !rvalid_d;
			if (ar_take) begin
				rresp_q <= RESP_OKAY;
				if (hit(araddr, OFS_CTRL)) begin
					rdata_q <= {31'h0, ctrl_q[CTRL_MEMEX_BIT]};
				end else if (hit(araddr, OFS_SEG_EN)) begin
					rdata_q <= 32'(seg_en_q[NCARDS-1:0]);
				end else if (hit(araddr, OFS_SEG_POL)) begin
					rdata_q <= 32'(seg_pol_q[NCARDS-1:0]);
				end else if (hit(araddr, OFS_ADDR)) begin
					rdata_q <= {16'h0, addr_q[15:0]};
				end else if (hit(araddr, OFS_WDATA)) begin
					rdata_q <= {24'h0, wbyte_q[7:0]};
				end else if (hit(araddr, OFS_CMD)) begin
					rdata_q <= 32'h0000_0000;
				end else if (hit(araddr, OFS_STATUS)) begin
					rdata_q <= {16'h0, rd_byte_q, 7'h0, (state_q != MCSEL_IDLE)};
				end else begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= RESP_DECERR;
				end
			end
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// ****************************************
	// bank and segment lines
	// ****************************************
	logic [NCARDS-1:0] seg_q;

	// one bit per card; enabled inverted cards see an actively driven low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_q <= '0;
		end else begin
			seg_q <= seg_en_q[NCARDS-1:0] ^ seg_pol_q[NCARDS-1:0]; // RULE15 RULE18
		end
	end

	// single driven bank line: one of two opposite-polarity cards responds
	assign memex_out = ctrl_q[CTRL_MEMEX_BIT]; // RULE16 RULE17
	assign segment_sel = seg_q;

	// ****************************************
	// memory cycle on the card bus
	// ****************************************
	logic [CNT_W-1:0] cnt_q;
	logic [15:0] bus_addr_q;
	logic [7:0] bus_dout_q;
	logic oe_n_q, memrq_n_q, rd_n_q, wr_n_q;
	logic [7:0] din_sync;

	mcsel_sync #(.W(8)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(bus_data_in),
		.dout(din_sync)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= MCSEL_IDLE;
			cnt_q <= '0;
			bus_addr_q <= '0;
			bus_dout_q <= '0;
			oe_n_q <= 1'b1;
			memrq_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			rd_byte_q <= '0;
		end else begin
			case (state_q)
				MCSEL_IDLE: begin
					if (start_rd || start_wr) begin
						state_q <= MCSEL_RUN;
						cnt_q <= CYCLE_LAST;
						bus_addr_q <= addr_q[15:0];
						bus_dout_q <= wbyte_q[7:0];
						oe_n_q <= !start_wr;
						memrq_n_q <= 1'b0;
						rd_n_q <= !start_rd;
						wr_n_q <= !start_wr;
					end
				end
				MCSEL_RUN: begin
					if (cnt_q == '0) begin
						state_q <= MCSEL_END;
						if (!rd_n_q) begin
							rd_byte_q <= din_sync;
						end
						memrq_n_q <= 1'b1;
						rd_n_q <= 1'b1;
						wr_n_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				MCSEL_END: begin
					state_q <= MCSEL_IDLE;
					oe_n_q <= 1'b1;
				end
				default: begin
					state_q <= MCSEL_IDLE;
				end
			endcase
		end
	end

	assign bus_addr = bus_addr_q;
	assign bus_data_out = bus_dout_q;
	assign bus_data_oe_n = oe_n_q;
	assign memrq_n = memrq_n_q;
	assign rd_n = rd_n_q;
	assign wr_n = wr_n_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_ctrl_write;
		do_write && hit(awaddr_q, OFS_CTRL) && wstrb_q[0];
	endsequence

	sequence s_cycle_start;
		(state_q == MCSEL_IDLE) && (start_rd || start_wr);
	endsequence

	AST_MEMEX_FOLLOWS: assert property (s_ctrl_write |=> // RULE16
		memex_out == $past(wdata_q[CTRL_MEMEX_BIT]))
		else $error("bank line did not take written level");
	AST_MEMEX_STEADY: assert property (!do_write |=> $stable(memex_out)) // RULE17
		else $error("bank line moved without a control write");
	AST_SEG_LEVEL: assert property (##1 segment_sel == // RULE18
		$past(seg_en_q[NCARDS-1:0] ^ seg_pol_q[NCARDS-1:0]))
		else $error("segment outputs do not follow enable and polarity");
	AST_SEG_INV_LOW: assert property (((seg_pol_q[NCARDS-1:0] & seg_en_q[NCARDS-1:0]) != '0) |=> // RULE15
		((segment_sel & $past(seg_pol_q[NCARDS-1:0] & seg_en_q[NCARDS-1:0])) == '0))
		else $error("inverted card not driven low when enabled");
	AST_CYCLE_HOLD: assert property (s_cycle_start |=> !memrq_n[*8] ##14 !memrq_n ##1 memrq_n)
		else $error("memory request not held for the cycle time");
	AST_CYCLE_STROBE: assert property (s_cycle_start ##1 !memrq_n |-> (rd_n != wr_n))
		else $error("cycle without exactly one strobe");
endmodule : mcsel_host

/* hdl/mcsel_pkg.sv */
package mcsel_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CYCLE_NS = 220;
	localparam int unsigned CYCLE_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;
	localparam logic [CNT_W-1:0] CYCLE_LAST = CNT_W'(CYCLE_CYC - 1);

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SEG_EN = 8'h04;
	localparam logic [7:0] OFS_SEG_POL = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0C;
	localparam logic [7:0] OFS_WDATA = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam int unsigned CTRL_MEMEX_BIT = 0;
	localparam int unsigned CMD_RD_BIT = 0;
	localparam int unsigned CMD_WR_BIT = 1;
	localparam int unsigned STATUS_BUSY_BIT = 0;
	localparam int unsigned STATUS_DATA_LSB = 8;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		MCSEL_IDLE = 2'b00,
		MCSEL_RUN = 2'b01,
		MCSEL_END = 2'b10
	} mcsel_state_t;
endpackage : mcsel_pkg

/* hdl/mcsel_sync.sv */
`timescale 1ns/10ps
module mcsel_sync #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit changes once stages two and three agree
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				out_q[i] <= 1'b0;
			end else if (s2_q[i] == s3_q[i]) begin
				out_q[i] <= s3_q[i];
			end
		end
	end

	assign dout = out_q;
endmodule : mcsel_sync

/* verification/mcsel_card_model.sv */
`timescale 1ns/10ps
module mcsel_card_model #(
	parameter bit TWO_BANK = 1'h0,
	parameter bit EXT_POL = 1'h0,
	parameter bit SEG_POL = 1'h0,
	parameter logic [7:0] DIS = 8'h00
) (
	input wire logic aclk,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_data_out,
	input wire logic memrq_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic memex,
	input wire logic seg_line,
	output logic drv,
	output logic [7:0] dout
);
	// ****************************************
	// card select path, all sockets 8K static RAM
	// ****************************************
	logic [7:0] mem [0:65535];
	logic ext_line;
	logic opt_in;
	logic ext_en;
	logic seg_en;
	logic dec;
	logic sel;
	logic [2:0] sock;
	// two-bank mode holds the card-enable path on
	assign ext_line = TWO_BANK ? 1'h0 : memex;
	assign opt_in = TWO_BANK ? memex : 1'h0;
	assign ext_en = TWO_BANK || (ext_line == EXT_POL);
	assign seg_en = seg_line ^ SEG_POL;
	assign sock = TWO_BANK ? {opt_in, bus_addr[14:13]} : bus_addr[15:13];
	assign dec = TWO_BANK ? bus_addr[15] : 1'h1;
	assign sel = !memrq_n && ext_en && seg_en && !DIS[sock] && dec;
	assign drv = sel && !rd_n;
	assign dout = mem[{sock, bus_addr[12:0]}];
	always_ff @(posedge aclk) begin
		if (sel && !wr_n) begin
			mem[{sock, bus_addr[12:0]}] <= bus_data_out;
		end
	end
endmodule : mcsel_card_model

/* verification/tb_memory_card_select_logic.sv */
`timescale 1ns/10ps
module tb_memory_card_select_logic import mcsel_pkg::*;;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, a_drv, b_drv;
	logic bus_data_oe_n, memrq_n, rd_n, wr_n, memex_out;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, s;
	logic [15:0] bus_addr;
	logic [7:0] bus_data_in, bus_data_out, segment_sel, a_d, b_d, q;
	logic [7:0] last_q = 8'h00;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc_cnt = 0;

	initial begin
		forever #5 aclk = ~aclk;
	end

	// ****************************************
	// released data lines show the inverse of the last byte
	// ****************************************
	assign bus_data_in = a_drv ? a_d : (b_drv ? b_d : ~last_q);
	always @(posedge aclk) begin
		if (a_drv || b_drv) last_q <= bus_data_in;
	end

	// during a memory request, host drives the data lines exactly while it strobes a write
	always @(posedge aclk) begin
		if (aresetn && !memrq_n) begin
			samples_checked++;
			if (bus_data_oe_n !== wr_n) begin
				error_cnt++;
				$display("[FAIL] %0t: data enable does not follow write strobe", $time);
			end
		end
	end

	mcsel_host u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
		.bus_data_oe_n(bus_data_oe_n), .memrq_n(memrq_n), .rd_n(rd_n), .wr_n(wr_n),
		.memex_out(memex_out), .segment_sel(segment_sel));
	mcsel_card_model #(.DIS(8'h20)) u_card_a (
		.aclk(aclk), .bus_addr(bus_addr), .bus_data_out(bus_data_out), .memrq_n(memrq_n),
		.rd_n(rd_n), .wr_n(wr_n), .memex(memex_out), .seg_line(segment_sel[0]),
		.drv(a_drv), .dout(a_d));
	mcsel_card_model #(.TWO_BANK(1'h1), .EXT_POL(1'h1), .SEG_POL(1'h1)) u_card_b (
		.aclk(aclk), .bus_addr(bus_addr), .bus_data_out(bus_data_out), .memrq_n(memrq_n),
		.rd_n(rd_n), .wr_n(wr_n), .memex(memex_out), .seg_line(segment_sel[1]),
		.drv(b_drv), .dout(b_d));

	task finish_test();
		if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test

	always @(posedge aclk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			finish_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!(bvalid && bready));
		bready <= 1'h0;
	endtask : axw

	task axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!(rvalid && rready));
		s = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask : axr

	// one card bus cycle, then wait for idle
	task cyc(input logic [15:0] a, input logic [7:0] d, input logic wr);
		axw(OFS_ADDR, {16'h0000, a});
		axw(OFS_WDATA, {24'h000000, d});
		axw(OFS_CMD, wr ? 32'h2 : 32'h1);
		do axr(OFS_STATUS); while (s[STATUS_BUSY_BIT] === 1'h1);
		q = s[STATUS_DATA_LSB +: 8];
	endtask : cyc

	task rd_chk(input logic [15:0] a, input logic [7:0] e);
		cyc(a, 8'h00, 1'h0);
		chk({24'h000000, q}, {24'h000000, e});
	endtask : rd_chk

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			axr(8'(4 * i));
			chk(s, REG_RESET);
			chk({30'h0, r}, {30'h0, RESP_OKAY});
		end
		axr(8'h1C);
		chk({30'h0, r}, {30'h0, RESP_DECERR});
		chk(s, 32'h0);
		chk({31'h0, memex_out}, 32'h0);
		wstrb <= 4'h0;
		axw(OFS_CTRL, 32'h1);
		wstrb <= 4'hF;
		chk({31'h0, memex_out}, 32'h0);
		axw(OFS_SEG_POL, 32'h2);
		axw(OFS_SEG_EN, 32'h1);
		repeat (2) @(posedge aclk);
		chk({24'h0, segment_sel}, 32'h03);
		cyc(16'h1234, 8'h5A, 1'h1);
		rd_chk(16'h1234, 8'h5A);
		axw(OFS_CTRL, 32'h1);
		rd_chk(16'h1234, 8'hA5);
		chk({31'h0, memex_out}, 32'h1);
		axw(OFS_CTRL, 32'h0);
		cyc(16'hA000, 8'hC3, 1'h1);
		rd_chk(16'hA000, 8'hA5);
		axw(OFS_SEG_EN, 32'h0);
		rd_chk(16'h1234, 8'hA5);
		axw(OFS_SEG_POL, 32'h2);
		axw(OFS_SEG_EN, 32'h2);
		repeat (2) @(posedge aclk);
		chk({24'h0, segment_sel}, 32'h00);
		cyc(16'h8000, 8'h11, 1'h1);
		axw(OFS_CTRL, 32'h1);
		cyc(16'h8000, 8'h22, 1'h1);
		rd_chk(16'h8000, 8'h22);
		axw(OFS_CTRL, 32'h0);
		rd_chk(16'h8000, 8'h11);
		rd_chk(16'h0100, 8'hEE);
		axw(OFS_SEG_EN, 32'h0);
		rd_chk(16'h8000, 8'hEE);
		finish_test();
	end
endmodule : tb_memory_card_select_logic
